/* dual_dac_update_control.sv */
`timescale 1ns/1ps
`include "dac_ctl_defines.svh"
// Functional notes
// - Two output channels, each with own data register
// - Twelve-bit code, output scales code over 4096
// - Whole code taken from one 16-bit write
// - Transparent mode updates written channel only, immediately
// - Double-buffered: both outputs update on channel-2 write
// - Double-buffered outputs hold their last codes (0 V after reset) until update
// - Double-buffered after reset; software may switch
module dual_dac_update_control
    import dac_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_rst,
    // Host write port (same clock domain)
    input  wire logic                    i_wr,
    input  wire logic                    i_sel,
    input  wire logic [`HOST_DATA_W-1:0] i_data,
    // Mode control
    input  wire logic                    i_mode_wr,
    input  wire logic                    i_mode_double_buf,
    // Converter side
    output logic      [`CODE_W-1:0]      o_analog_out_first,
    output logic      [`CODE_W-1:0]      o_analog_out_second,
    output logic                         o_update,
    // Status
    output logic                         o_double_buf
);
    update_mode_e mode;
    update_mode_e next_mode;
    code_t        out_first;
    code_t        out_second;
    code_t        next_out_first;
    code_t        next_out_second;
    logic         upd;
    logic         next_upd;

    code_bus_if bus ();

    // Mode register: double-buffered out of reset, host may change any time
    always_comb
    begin
        next_mode = mode;
        if (i_mode_wr)
        begin
            next_mode = i_mode_double_buf ? MODE_DOUBLE_BUF : MODE_TRANSPARENT;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            mode <= MODE_DOUBLE_BUF;
        end
        else
        begin
            mode <= next_mode;
        end
    end

    // Decode the write into a per-channel strobe; upper data bits are ignored
    assign bus.wr_first   = i_wr && (i_sel == `SEL_FIRST);
    assign bus.wr_second  = i_wr && (i_sel == `SEL_SECOND);
    assign bus.wr_code    = i_data[`CODE_W-1:0];
    assign bus.double_buf = (mode == MODE_DOUBLE_BUF);

    code_store u_store
    (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .bus       (bus.store)
    );

    // Output retiming so every port comes from a flip-flop
    always_comb
    begin
        next_out_first  = bus.out_first;
        next_out_second = bus.out_second;
        next_upd        = bus.updated;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            out_first  <= `CODE_RESET;
            out_second <= `CODE_RESET;
            upd        <= 1'b0;
        end
        else
        begin
            out_first  <= next_out_first;
            out_second <= next_out_second;
            upd        <= next_upd;
        end
    end

    assign o_analog_out_first  = out_first;
    assign o_analog_out_second = out_second;
    assign o_update            = upd;
    assign o_double_buf        = (mode == MODE_DOUBLE_BUF);
endmodule

/* dac_ctl_defines.svh */
`ifndef DAC_CTL_DEFINES_SVH
`define DAC_CTL_DEFINES_SVH

// Code width and full-scale divisor of each converter
`define CODE_W          12
`define CODE_FULL_SCALE 4096
// Host data bus width
`define HOST_DATA_W     16
// Channel select values on the host address bit
`define SEL_FIRST       1'b0
`define SEL_SECOND      1'b1
// Reset values
`define CODE_RESET      12'h000
`define MODE_RESET      1'b1

`endif

/* dac_ctl_pkg.sv */
package dac_ctl_pkg;
    `include "dac_ctl_defines.svh"

    // Output update mode
    typedef enum logic [0:0]
    {
        MODE_TRANSPARENT = 1'b0,
        MODE_DOUBLE_BUF  = 1'b1
    } update_mode_e;

    typedef logic [`CODE_W-1:0] code_t;
endpackage

/* code_bus_if.sv */
`timescale 1ns/1ps
// Carries a decoded channel write into the code store
interface code_bus_if;
    import dac_ctl_pkg::*;
    logic  wr_first;
    logic  wr_second;
    logic  double_buf;
    code_t wr_code;
    code_t out_first;
    code_t out_second;
    logic  updated;

    modport ctl   (output wr_first, output wr_second, output double_buf, output wr_code,
                   input out_first, input out_second, input updated);
    modport store (input wr_first, input wr_second, input double_buf, input wr_code,
                   output out_first, output out_second, output updated);
endinterface

/* code_store.sv */
`timescale 1ns/1ps
`include "dac_ctl_defines.svh"
// Two-stage code holding: first stage per channel, second stage drives converters
module code_store
    import dac_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    // Write and output bundle
    code_bus_if.store bus
);
    code_t hold [2];
    code_t live [2];
    logic  upd;
    code_t next_hold [2];
    code_t next_live [2];
    logic  next_upd;
    logic  wr [2];

    assign wr[0] = bus.wr_first;
    assign wr[1] = bus.wr_second;

    // Per-channel next values; same loop serves both converters
    always_comb
    begin
        next_upd = 1'b0;
        for (int ch = 0; ch < 2; ch++)
        begin
            next_hold[ch] = hold[ch];
            next_live[ch] = live[ch];
            if (wr[ch])
            begin
                next_hold[ch] = bus.wr_code;                    // whole code in one access
                if (!bus.double_buf)
                begin
                    next_live[ch] = bus.wr_code;                // only this channel moves
                end
            end
        end
        if (bus.double_buf && bus.wr_second)
        begin
            // Channel 1 code was staged earlier; both move in one edge
            next_live[0] = bus.wr_first ? bus.wr_code : hold[0];
            next_live[1] = bus.wr_code;
            next_upd     = 1'b1;
        end
    end

    // Converter codes clear at reset so both outputs sit at 0 V
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            hold[0] <= `CODE_RESET;
            hold[1] <= `CODE_RESET;
            live[0] <= `CODE_RESET;
            live[1] <= `CODE_RESET;
            upd     <= 1'b0;
        end
        else
        begin
            hold <= next_hold;
            live <= next_live;
            upd  <= next_upd;
        end
    end

    assign bus.out_first  = live[0];
    assign bus.out_second = live[1];
    assign bus.updated    = upd;
endmodule

/* dual_dac_update_control_props.sv */
`timescale 1ns/1ps
`include "dac_ctl_defines.svh"
// Watches update timing from the top ports only
module dual_dac_update_control_props
(
    // Clock, reset and host side
    input wire logic                    i_ref_clk,
    input wire logic                    i_rst,
    input wire logic                    i_wr,
    input wire logic                    i_sel,
    input wire logic [`HOST_DATA_W-1:0] i_data,
    input wire logic                    i_mode_wr,
    input wire logic                    i_mode_double_buf,
    // Converter side
    input wire logic [`CODE_W-1:0]      o_analog_out_first,
    input wire logic [`CODE_W-1:0]      o_analog_out_second,
    input wire logic                    o_update,
    input wire logic                    o_double_buf
);
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    // Held channel-1 code, one idle cycle, then the releasing channel-2 write
    sequence s_hold;
        i_wr && !i_sel && o_double_buf ##1 !i_wr ##1 i_wr && i_sel && o_double_buf;
    endsequence
    a_trans_first_now: assert property (i_wr && !i_sel && !o_double_buf |->
        ##2 o_analog_out_first == $past(i_data[11:0], 2)) else $error("first late");
    a_second_needs_write: assert property (!$past(i_wr && i_sel, 2) |->
        $stable(o_analog_out_second)) else $error("second moved");
    a_dbl_first_held: assert property ($past(o_double_buf, 2) && !$past(i_wr && i_sel, 2) |->
        $stable(o_analog_out_first)) else $error("first moved");
    a_dbl_joint_update: assert property (i_wr && i_sel && o_double_buf |->
        ##2 o_update && o_analog_out_second == $past(i_data[11:0], 2)) else $error("joint update");
    a_held_code_release: assert property (s_hold |->
        ##2 o_analog_out_first == $past(i_data[11:0], 4)) else $error("held code lost");
    a_update_pulse_cause: assert property (o_update ==
        $past(i_wr && i_sel && o_double_buf, 2)) else $error("update pulse");
    a_reset_zero_dbl: assert property (disable iff (1'b0) i_rst |->
        o_double_buf && o_analog_out_first == 0 && o_analog_out_second == 0) else $error("reset state");
    a_mode_load_next: assert property (i_mode_wr |=>
        o_double_buf == $past(i_mode_double_buf)) else $error("mode load");
endmodule
bind dual_dac_update_control dual_dac_update_control_props u_props (.*);

/* host_model.sv */
`timescale 1ns/1ps
// Host side: whole-word writes launched just after the edge
module host_model
(
    // Clock in, bus out
    input  wire logic        i_ref_clk,
    output logic             o_wr,
    output logic             o_sel,
    output logic      [15:0] o_data,
    output logic             o_mode_wr,
    output logic             o_mode_double_buf
);
    initial {o_wr, o_sel, o_data, o_mode_wr, o_mode_double_buf} = '0;
    // Released data shows its inverse so a stale word never looks valid
    task automatic wr(input logic sel, input logic [15:0] data);
        @(posedge i_ref_clk);
        #1 {o_wr, o_sel, o_data} = {1'b1, sel, data};
        @(posedge i_ref_clk);
        #1 {o_wr, o_data} = {1'b0, ~data};
    endtask
    // Mode strobe
    task automatic mode(input logic db);
        @(posedge i_ref_clk);
        #1 {o_mode_wr, o_mode_double_buf} = {1'b1, db};
        @(posedge i_ref_clk);
        #1 o_mode_wr = 1'b0;
    endtask
endmodule

/* tb_dual_dac_update_control.sv */
`timescale 1ns/1ps
// Drives the update controller through both modes
module tb_dual_dac_update_control
    import dac_ctl_pkg::*;
;
    logic        i_ref_clk = 1'b0;
    logic        i_rst = 1'b0;
    logic        wr, sel, mode_wr, mode_db, upd, dbuf;
    logic [15:0] data;
    code_t       out1, out2;
    int          n_fail = 0;
    int          n_compared = 0;
    always #25 i_ref_clk = ~i_ref_clk;
    host_model host (.i_ref_clk(i_ref_clk), .o_wr(wr), .o_sel(sel), .o_data(data), .o_mode_wr(mode_wr),
        .o_mode_double_buf(mode_db));
    dual_dac_update_control dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wr(wr), .i_sel(sel), .i_data(data),
        .i_mode_wr(mode_wr), .i_mode_double_buf(mode_db), .o_analog_out_first(out1),
        .o_analog_out_second(out2), .o_update(upd), .o_double_buf(dbuf));
    // One comparison
    task automatic ck(input string nm, input logic [11:0] exp, input logic [11:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Outputs land one edge after the write task returns
    task automatic see(input code_t e1, input code_t e2, input logic eu);
        @(posedge i_ref_clk);
        #1 ck("first", e1, out1);
        ck("second", e2, out2);
        ck("update", {11'h000, eu}, {11'h000, upd});
    endtask
    task automatic t_reset;
        ck("mode", 12'h001, {11'h000, dbuf});
        see(12'h000, 12'h000, 1'b0);
        $display("t_reset end");
    endtask
    // Pair one idle cycle apart; upper data bits must be dropped
    task automatic t_double;
        host.wr(1'b0, 16'hf123);
        host.wr(1'b1, 16'h0fff);
        ck("first", 12'h000, out1);
        see(12'h123, 12'hfff, 1'b1);
        see(12'h123, 12'hfff, 1'b0);
        $display("t_double end");
    endtask
    task automatic t_trans;
        host.mode(1'b0);
        ck("mode", 12'h000, {11'h000, dbuf});
        host.wr(1'b0, 16'h0abc);
        see(12'habc, 12'hfff, 1'b0);
        host.wr(1'b1, 16'ha000);
        see(12'habc, 12'h000, 1'b0);
        $display("t_trans end");
    endtask
    // Holding stage kept loading, so channel 2 releases the last channel-1 code
    task automatic t_back;
        host.mode(1'b1);
        host.wr(1'b1, 16'h0555);
        see(12'habc, 12'h555, 1'b1);
        $display("t_back end");
    endtask
    task automatic complete_run;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #1 i_rst = 1'b1; // A real rising edge, so the async reset fires before the first clock
        repeat (4) @(posedge i_ref_clk);
        #1 i_rst = 1'b0;
        t_reset;
        t_double;
        t_trans;
        t_back;
        complete_run;
    end
    // Watchdog, about seventeen times the expected run
    initial
    begin
        #20000;
        n_fail++;
        complete_run;
    end
endmodule
